// >>> bmf_pkg.sv
package bmf_pkg;

  // ==========================================================
  // Widths
  localparam int LONG_W   = 36;
  localparam int NARROW_W = 18;
  localparam int LANE_W   = 9;
  localparam int OFS_W    = 11;

  // ==========================================================
  // Index of last part per long word
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [1:0] LAST_WORD = 2'h1;

  // ==========================================================
  // Offset load order: index of each offset register
  localparam logic [1:0] OFS_FIRST_HIGH  = 2'h0;
  localparam logic [1:0] OFS_FIRST_LOW   = 2'h1;
  localparam logic [1:0] OFS_SECOND_HIGH = 2'h2;
  localparam logic [1:0] OFS_SECOND_LOW  = 2'h3;
  localparam logic [OFS_W-1:0] OFS_RESET = 11'h008;

  // ==========================================================
  // Reset timing in clk_sys_in cycles
  localparam logic [3:0] RDY_DLY_CYC    = 4'h2;
  localparam logic [3:0] HOST_RST_CYC   = 4'h4;
  localparam logic [3:0] HOST_RST_LIMIT = 4'hF;

  // ==========================================================
  // Host sequencer states
  typedef enum logic [1:0] {
    BMF_H_IDLE  = 2'b00,
    BMF_H_RESET = 2'b01,
    BMF_H_WAIT  = 2'b10,
    BMF_H_RUN   = 2'b11
  } bmf_hstate_e;

endpackage

// >>> bmf_if.sv
`timescale 1ns/10ps
interface bmf_if;
  import bmf_pkg::*;

  // Reset and configuration pins (host drives)
  logic                first_queue_full_init_n;
  logic                second_queue_full_init_n;
  logic                first_queue_data_clear_n;
  logic                second_queue_data_clear_n;
  logic                rx_port_mailbox_select;
  logic                endian_order_select;
  logic                fall_through_timing;
  logic                tx_port_width_select;
  logic                rx_port_width_select;
  logic                serial_offset_input;
  logic                serial_offset_strobe;
  // Narrow ports
  logic                tx_read_en;
  logic [NARROW_W-1:0] tx_data;
  logic                rx_write_en;
  logic [NARROW_W-1:0] rx_data;
  // Flags (device drives)
  logic                first_queue_write_ready;
  logic                second_queue_write_ready;
  logic                first_queue_read_ready;

  modport dev (
    input  first_queue_full_init_n, second_queue_full_init_n,
    input  first_queue_data_clear_n, second_queue_data_clear_n,
    input  rx_port_mailbox_select, endian_order_select, fall_through_timing,
    input  tx_port_width_select, rx_port_width_select,
    input  serial_offset_input, serial_offset_strobe,
    input  tx_read_en, rx_write_en, rx_data,
    output tx_data, first_queue_write_ready, second_queue_write_ready,
    output first_queue_read_ready
  );

  modport host (
    output first_queue_full_init_n, second_queue_full_init_n,
    output first_queue_data_clear_n, second_queue_data_clear_n,
    output rx_port_mailbox_select, endian_order_select, fall_through_timing,
    output tx_port_width_select, rx_port_width_select,
    output serial_offset_input, serial_offset_strobe,
    output tx_read_en, rx_write_en, rx_data,
    input  tx_data, first_queue_write_ready, second_queue_write_ready,
    input  first_queue_read_ready
  );
endinterface

// >>> bmf_dev.sv
`timescale 1ns/10ps
// Overview of operation
// - Fetch long word, emit parts one by one
// - Byte mode: upper tx lines carry nothing
// - Last rx part commits whole long word
// - Byte mode: upper rx lines ignored
// - Rx word order follows endian select
// - Rx byte order follows endian select
// - Tx word order follows endian select
// - Tx byte order follows endian select
// - Host fixes endian, widths stay static
// - Host holds clear, mailbox high in reset
// - Both master resets toggle together
// - Master reset high during partial reset
// - Fall-through read flag drops cycle earlier
// - Writes ignored until both ready flags
// - Serial offsets: high1, low1, high2, low2
// - Offset loads may skip idle cycles
// - Endian latched at master reset rise
// - Width selects effective by reset end
module bmf_dev
  import bmf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  input  wire logic                ce_in,
  // Link to host
  bmf_if.dev                       link,
  // First queue memory, read side
  input  wire logic                q1_valid_in,
  input  wire logic [LONG_W-1:0]   q1_data_in,
  output logic                     q1_pop_out,
  // Second queue memory, write side
  input  wire logic                q2_space_in,
  output logic                     q2_push_out,
  output logic [LONG_W-1:0]        q2_data_out,
  // Wide-port parallel offset load
  input  wire logic                par_load_in,
  input  wire logic [LONG_W-1:0]   par_data_in,
  // Offsets
  output logic [OFS_W-1:0]         first_queue_high_offset_out,
  output logic [OFS_W-1:0]         first_queue_low_offset_out,
  output logic [OFS_W-1:0]         second_queue_high_offset_out,
  output logic [OFS_W-1:0]         second_queue_low_offset_out
);

  // ==========================================================
  // Lane helpers
  function automatic logic [1:0] lane_of(input logic [1:0] idx, input logic byte_m,
                                         input logic big);
    logic [1:0] l;
    l = 2'h0;
    if (byte_m)
      l = big ? (LAST_BYTE - idx) : idx;
    else
      l = (big ? (LAST_WORD - idx) : idx) << 1;
    return l;
  endfunction

  function automatic logic [NARROW_W-1:0] tx_part(input logic [LONG_W-1:0] lw,
                                                  input logic [1:0] idx,
                                                  input logic byte_m, input logic big);
    logic [1:0] l;
    l = lane_of(idx, byte_m, big);
    if (byte_m)
      return {9'h000, lw[LANE_W*l +: LANE_W]};
    return lw[LANE_W*l +: NARROW_W];
  endfunction

  function automatic logic [LONG_W-1:0] rx_place(input logic [LONG_W-1:0] lw,
                                                 input logic [NARROW_W-1:0] d,
                                                 input logic [1:0] idx,
                                                 input logic byte_m, input logic big);
    logic [LONG_W-1:0] r;
    logic [1:0]        l;
    r = lw;
    l = lane_of(idx, byte_m, big);
    if (byte_m)
      r[LANE_W*l +: LANE_W] = d[LANE_W-1:0];
    else
      r[LANE_W*l +: NARROW_W] = d;
    return r;
  endfunction

  // ==========================================================
  // Reset tracking and configuration latch
  logic       in_mrs;
  logic       mrs_d_ff;
  logic       rst_d_ff;
  logic       big_ff;
  logic       fall_through_timing_ff;
  logic       tx_byte_ff;
  logic       rx_byte_ff;
  logic [3:0] rdy_cnt_ff;
  logic       init_done_ff;
  logic       tx_clear;
  logic       rx_clear;

  assign in_mrs   = ~link.first_queue_full_init_n | ~link.second_queue_full_init_n;
  assign tx_clear = in_mrs | ~link.first_queue_data_clear_n;
  assign rx_clear = in_mrs | ~link.second_queue_data_clear_n;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      mrs_d_ff   <= 1'b0;
      rst_d_ff   <= 1'b0;
      big_ff     <= 1'b1;
      fall_through_timing_ff    <= 1'b0;
      tx_byte_ff <= 1'b0;
      rx_byte_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      mrs_d_ff <= in_mrs;
      rst_d_ff <= tx_clear | rx_clear;
      if (mrs_d_ff && !in_mrs)
      begin
        big_ff     <= link.endian_order_select;
        fall_through_timing_ff    <= link.fall_through_timing;
        tx_byte_ff <= link.tx_port_width_select;
        rx_byte_ff <= link.rx_port_width_select;
      end
    end
  end

  // Ready flags wait for the latch above, so widths apply before first use
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      rdy_cnt_ff   <= 4'h0;
      init_done_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (in_mrs)
      begin
        rdy_cnt_ff   <= 4'h0;
        init_done_ff <= 1'b0;
      end
      else if (rdy_cnt_ff < RDY_DLY_CYC)
        rdy_cnt_ff <= rdy_cnt_ff + 4'h1;
      else
        init_done_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Transmit unpacking
  logic [LONG_W-1:0]   hold_ff;
  logic [1:0]          tx_idx_ff;
  logic                loaded_ff;
  logic [NARROW_W-1:0] tx_data_ff;
  logic                tx_rdy_ff;
  logic                q1_pop_ff;
  logic [1:0]          tx_last;
  logic                tx_take;
  logic                tx_fetch;

  assign tx_last  = tx_byte_ff ? LAST_BYTE : LAST_WORD;
  assign tx_take  = link.tx_read_en & loaded_ff & tx_rdy_ff;
  assign tx_fetch = ~loaded_ff & q1_valid_in & init_done_ff & ~tx_clear & ~q1_pop_ff;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      hold_ff    <= '0;
      tx_idx_ff  <= 2'h0;
      loaded_ff  <= 1'b0;
      tx_data_ff <= '0;
      q1_pop_ff  <= 1'b0;
    end
    else if (ce_in)
    begin
      q1_pop_ff <= tx_fetch;
      if (tx_clear)
      begin
        loaded_ff <= 1'b0;
        tx_idx_ff <= 2'h0;
      end
      else if (tx_fetch)
      begin
        hold_ff    <= q1_data_in;
        loaded_ff  <= 1'b1;
        tx_idx_ff  <= 2'h0;
        tx_data_ff <= tx_part(q1_data_in, 2'h0, tx_byte_ff, big_ff);
      end
      else if (tx_take)
      begin
        if (tx_idx_ff == tx_last)
          loaded_ff <= 1'b0;
        else
        begin
          tx_idx_ff  <= tx_idx_ff + 2'h1;
          tx_data_ff <= tx_part(hold_ff, tx_idx_ff + 2'h1, tx_byte_ff, big_ff);
        end
      end
    end
  end

  // Standard mode drops the flag one cycle after fall-through mode does
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      tx_rdy_ff <= 1'b0;
    else if (ce_in)
    begin
      if (fall_through_timing_ff ? tx_clear : rst_d_ff)
        tx_rdy_ff <= 1'b0;
      else if (tx_take && tx_idx_ff == tx_last)
        tx_rdy_ff <= 1'b0;
      else
        tx_rdy_ff <= loaded_ff | tx_fetch;
    end
  end

  // ==========================================================
  // Receive packing
  logic [LONG_W-1:0] pack_ff;
  logic [1:0]        rx_idx_ff;
  logic              q2_push_ff;
  logic [LONG_W-1:0] q2_data_ff;
  logic              wr_rdy1_ff;
  logic              wr_rdy2_ff;
  logic              rx_take;
  logic              rx_byte_now;
  logic [1:0]        rx_last;

  assign rx_last     = rx_byte_ff ? LAST_BYTE : LAST_WORD;
  assign rx_byte_now = rx_byte_ff;
  assign rx_take     = link.rx_write_en & ~link.rx_port_mailbox_select
                       & wr_rdy1_ff & wr_rdy2_ff & ~rx_clear;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pack_ff    <= '0;
      rx_idx_ff  <= 2'h0;
      q2_push_ff <= 1'b0;
      q2_data_ff <= '0;
    end
    else if (ce_in)
    begin
      q2_push_ff <= 1'b0;
      if (rx_clear)
        rx_idx_ff <= 2'h0;
      else if (rx_take)
      begin
        // Byte mode reads only the low lane, upper inputs never reach storage
        pack_ff <= rx_place(pack_ff, link.rx_data, rx_idx_ff, rx_byte_now,
                            big_ff);
        if (rx_idx_ff == rx_last)
        begin
          q2_push_ff <= 1'b1;
          q2_data_ff <= rx_place(pack_ff, link.rx_data, rx_idx_ff, rx_byte_now, big_ff);
          rx_idx_ff  <= 2'h0;
        end
        else
          rx_idx_ff <= rx_idx_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      wr_rdy1_ff <= 1'b0;
      wr_rdy2_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      wr_rdy1_ff <= init_done_ff & ~tx_clear;
      // Space is judged one word early so a push in flight cannot overrun
      wr_rdy2_ff <= init_done_ff & ~rx_clear & q2_space_in & ~q2_push_ff;
    end
  end

  // ==========================================================
  // Offset registers, loaded serially or from the wide port
  logic [OFS_W-1:0] ofs_ff [4];
  logic [1:0]       ofs_idx_ff;
  logic [3:0]       ofs_bit_ff;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      ofs_idx_ff <= 2'h0;
      ofs_bit_ff <= 4'h0;
    end
    else if (ce_in)
    begin
      if (in_mrs)
      begin
        ofs_idx_ff <= 2'h0;
        ofs_bit_ff <= 4'h0;
      end
      else if (link.serial_offset_strobe)
      begin
        if (ofs_bit_ff == 4'(OFS_W - 1))
        begin
          ofs_bit_ff <= 4'h0;
          ofs_idx_ff <= ofs_idx_ff + 2'h1;
        end
        else
          ofs_bit_ff <= ofs_bit_ff + 4'h1;
      end
      else if (par_load_in)
        ofs_idx_ff <= ofs_idx_ff + 2'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ofs
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_n_in)
          ofs_ff[g] <= OFS_RESET;
        else if (ce_in && !in_mrs && ofs_idx_ff == 2'(g))
        begin
          if (link.serial_offset_strobe)
            ofs_ff[g] <= {ofs_ff[g][OFS_W-2:0], link.serial_offset_input};
          else if (par_load_in)
            ofs_ff[g] <= par_data_in[OFS_W-1:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign link.tx_data                  = tx_data_ff;
  assign link.first_queue_read_ready   = tx_rdy_ff;
  assign link.first_queue_write_ready  = wr_rdy1_ff;
  assign link.second_queue_write_ready = wr_rdy2_ff;
  assign q1_pop_out                    = q1_pop_ff;
  assign q2_push_out                   = q2_push_ff;
  assign q2_data_out                   = q2_data_ff;
  assign first_queue_high_offset_out   = ofs_ff[OFS_FIRST_HIGH];
  assign first_queue_low_offset_out    = ofs_ff[OFS_FIRST_LOW];
  assign second_queue_high_offset_out  = ofs_ff[OFS_SECOND_HIGH];
  assign second_queue_low_offset_out   = ofs_ff[OFS_SECOND_LOW];

endmodule

// >>> bmf_host.sv
`timescale 1ns/10ps
module bmf_host
  import bmf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                clk_sys_in,
  input  wire logic                rst_n_in,
  input  wire logic                ce_in,
  // Link to device
  bmf_if.host                      link,
  // Configuration, sampled when a reset is started
  input  wire logic                start_reset_in,
  input  wire logic                big_endian_in,
  input  wire logic                fall_through_in,
  input  wire logic                tx_byte_in,
  input  wire logic                rx_byte_in,
  // User requests
  input  wire logic                rd_req_in,
  input  wire logic                wr_req_in,
  input  wire logic [NARROW_W-1:0] wr_data_in,
  input  wire logic                ser_req_in,
  input  wire logic                ser_bit_in,
  // Status
  output logic                     busy_out,
  output logic                     rd_valid_out,
  output logic [NARROW_W-1:0]      rd_data_out
);

  // ==========================================================
  // Reset sequencer
  bmf_hstate_e state_ff;
  logic [3:0]  cnt_ff;
  logic        mrs_n_ff;
  logic        big_ff;
  logic        fall_through_timing_ff;
  logic        txb_ff;
  logic        rxb_ff;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= BMF_H_IDLE;
      cnt_ff   <= 4'h0;
      mrs_n_ff <= 1'b1;
      big_ff   <= 1'b1;
      fall_through_timing_ff  <= 1'b0;
      txb_ff   <= 1'b0;
      rxb_ff   <= 1'b0;
    end
    else if (ce_in)
    begin
      case (state_ff)
        // A new reset may start from idle or from normal running
        BMF_H_IDLE, BMF_H_RUN:
        begin
          if (start_reset_in)
          begin
            // Widths are captured once and held static until the next reset
            big_ff   <= big_endian_in;
            fall_through_timing_ff  <= fall_through_in;
            txb_ff   <= tx_byte_in;
            rxb_ff   <= rx_byte_in;
            mrs_n_ff <= 1'b0;
            cnt_ff   <= 4'h0;
            state_ff <= BMF_H_RESET;
          end
        end
        BMF_H_RESET:
        begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == HOST_RST_CYC - 4'h1)
          begin
            mrs_n_ff <= 1'b1;
            cnt_ff   <= 4'h0;
            state_ff <= BMF_H_WAIT;
          end
        end
        BMF_H_WAIT:
        begin
          if (link.first_queue_write_ready && link.second_queue_write_ready)
            state_ff <= BMF_H_RUN;
          else if (cnt_ff == HOST_RST_LIMIT)
            state_ff <= BMF_H_IDLE;
          else
            cnt_ff <= cnt_ff + 4'h1;
        end
        default:
          state_ff <= BMF_H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Port traffic, all registered; read and write enables are one-cycle strobes
  logic                rd_en_ff;
  logic                wr_en_ff;
  logic [NARROW_W-1:0] wr_data_ff;
  logic                ser_ff;
  logic                ser_bit_ff;
  logic                rd_valid_ff;
  logic [NARROW_W-1:0] rd_data_ff;
  logic                run;

  assign run = (state_ff == BMF_H_RUN);

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      rd_en_ff    <= 1'b0;
      wr_en_ff    <= 1'b0;
      wr_data_ff  <= '0;
      ser_ff      <= 1'b0;
      ser_bit_ff  <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end
    else if (ce_in)
    begin
      rd_en_ff    <= run & rd_req_in & link.first_queue_read_ready & ~rd_en_ff;
      rd_valid_ff <= rd_en_ff;
      if (rd_en_ff)
        rd_data_ff <= link.tx_data;
      wr_en_ff    <= run & wr_req_in & link.second_queue_write_ready & ~wr_en_ff;
      if (wr_req_in)
        wr_data_ff <= wr_data_in;
      // Serial bits go in high offset first, as the device counts them
      ser_ff      <= run & ser_req_in;
      ser_bit_ff  <= ser_bit_in;
    end
  end

  // ==========================================================
  // Pins
  assign link.first_queue_full_init_n   = mrs_n_ff;
  assign link.second_queue_full_init_n  = mrs_n_ff;
  assign link.first_queue_data_clear_n  = 1'b1;
  assign link.second_queue_data_clear_n = 1'b1;
  assign link.rx_port_mailbox_select    = (state_ff != BMF_H_RUN);
  assign link.endian_order_select       = big_ff;
  assign link.fall_through_timing       = fall_through_timing_ff;
  assign link.tx_port_width_select      = txb_ff;
  assign link.rx_port_width_select      = rxb_ff;
  assign link.serial_offset_input       = ser_bit_ff;
  assign link.serial_offset_strobe      = ser_ff;
  assign link.tx_read_en                = rd_en_ff;
  assign link.rx_write_en               = wr_en_ff;
  assign link.rx_data                   = wr_data_ff;
  assign busy_out                       = ~run;
  assign rd_valid_out                   = rd_valid_ff;
  assign rd_data_out                    = rd_data_ff;

endmodule

// >>> bmf_monitor.sv
`timescale 1ns/10ps
module bmf_monitor
  import bmf_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // Link signals
  input  wire logic first_queue_full_init_n,
  input  wire logic second_queue_full_init_n,
  input  wire logic first_queue_data_clear_n,
  input  wire logic second_queue_data_clear_n,
  input  wire logic rx_port_mailbox_select,
  input  wire logic endian_order_select,
  input  wire logic fall_through_timing,
  input  wire logic tx_port_width_select,
  input  wire logic rx_port_width_select,
  input  wire logic tx_read_en,
  input  wire logic rx_write_en,
  input  wire logic first_queue_write_ready,
  input  wire logic second_queue_write_ready,
  input  wire logic first_queue_read_ready
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================
  // Helper state
  logic [1:0] take_cnt_ff;
  logic       fall_through_timing_ff;
  wire  logic [1:0] last_part = tx_port_width_select ? LAST_BYTE : LAST_WORD;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !first_queue_read_ready)
      take_cnt_ff <= 2'h0;
    else if (tx_read_en)
      take_cnt_ff <= take_cnt_ff + 2'h1;
  end

  // Timing mode in force is the one latched at the previous master reset
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      fall_through_timing_ff <= 1'b0;
    else if ($rose(first_queue_full_init_n))
      fall_through_timing_ff <= fall_through_timing;
  end

  // ==========================================
  // Properties
  sequence s_take;
    tx_read_en && first_queue_read_ready;
  endsequence
  sequence s_init_done;
    !first_queue_write_ready [*3] ##[1:5] (first_queue_write_ready && second_queue_write_ready);
  endsequence

  property p_init_pair;
    first_queue_full_init_n == second_queue_full_init_n;
  endproperty
  property p_hold_cfg;
    !first_queue_full_init_n |->
      rx_port_mailbox_select && first_queue_data_clear_n && second_queue_data_clear_n;
  endproperty
  property p_ready_rise;
    $rose(first_queue_full_init_n) |-> s_init_done;
  endproperty
  property p_cfg_static;
    first_queue_write_ready && $past(first_queue_write_ready) && first_queue_full_init_n
      |-> $stable(tx_port_width_select) && $stable(rx_port_width_select)
          && $stable(endian_order_select);
  endproperty
  property p_write_gate;
    rx_write_en && !rx_port_mailbox_select |->
      first_queue_write_ready && second_queue_write_ready;
  endproperty
  property p_last_part;
    s_take ##0 (take_cnt_ff == last_part) |=> !first_queue_read_ready;
  endproperty
  property p_mid_part;
    s_take ##0 (take_cnt_ff != last_part) |=> first_queue_read_ready;
  endproperty
  property p_fall_through_timing;
    $fell(first_queue_full_init_n) |->
      if (fall_through_timing_ff) ##1 !first_queue_read_ready else ##2 !first_queue_read_ready;
  endproperty

  a_init_pair: assert property (p_init_pair)
    else $error("master resets differ");
  a_hold_cfg: assert property (p_hold_cfg)
    else $error("mailbox or clear low in master reset");
  a_ready_rise: assert property (p_ready_rise)
    else $error("write ready timing wrong");
  a_cfg_static: assert property (p_cfg_static)
    else $error("config changed while running");
  a_write_gate: assert property (p_write_gate)
    else $error("write before ready");
  a_last_part: assert property (p_last_part)
    else $error("read ready kept after last part");
  a_mid_part: assert property (p_mid_part)
    else $error("read ready lost mid word");
  a_fall_through_timing: assert property (p_fall_through_timing)
    else $error("read ready drop timing wrong");
endmodule

// >>> bus_matching_fifo_ports_tb_top.sv
`timescale 1ns/10ps
module bus_matching_fifo_ports_tb_top;
  import bmf_pkg::*;
  // ==========================================
  // Signals
  localparam logic [LONG_W-1:0] W0 = 36'h9_A5C3_1E7B;
  localparam logic [OFS_W-1:0]  OV [4] = '{11'h3A5, 11'h15A, 11'h6C3, 11'h03C};
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, q2_space_in = 1'b1;
  logic q1_valid_in = 1'b0, par_load_in = 1'b0, q1_pop_out, q2_push_out;
  logic [LONG_W-1:0] q1_data_in = '0, par_data_in = '0, q2_data_out, push_word;
  logic [OFS_W-1:0]  ofs [4];
  logic start_reset_in = 1'b0, big_endian_in = 1'b0, fall_through_in = 1'b0;
  logic tx_byte_in = 1'b0, rx_byte_in = 1'b0, rd_req_in = 1'b0, wr_req_in = 1'b0;
  logic ser_req_in = 1'b0, ser_bit_in = 1'b0, busy_out, rd_valid_out;
  logic [NARROW_W-1:0] wr_data_in = '0, rd_data_out;
  int   n_mismatch = 0, total_checks = 0, n_push = 0, cyc = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  bmf_if bus ();
  bmf_dev bmf_dev_i (.clk_sys_in, .rst_n_in, .ce_in, .link(bus), .q1_valid_in, .q1_data_in,
    .q1_pop_out, .q2_space_in, .q2_push_out, .q2_data_out, .par_load_in, .par_data_in,
    .first_queue_high_offset_out(ofs[0]), .first_queue_low_offset_out(ofs[1]),
    .second_queue_high_offset_out(ofs[2]), .second_queue_low_offset_out(ofs[3]));
  bmf_host bmf_host_i (.clk_sys_in, .rst_n_in, .ce_in, .link(bus), .start_reset_in,
    .big_endian_in, .fall_through_in, .tx_byte_in, .rx_byte_in, .rd_req_in, .wr_req_in,
    .wr_data_in, .ser_req_in, .ser_bit_in, .busy_out, .rd_valid_out, .rd_data_out);
  bmf_monitor bmf_monitor_i (.clk_sys_in, .rst_n_in,
    .first_queue_full_init_n(bus.first_queue_full_init_n),
    .second_queue_full_init_n(bus.second_queue_full_init_n),
    .first_queue_data_clear_n(bus.first_queue_data_clear_n),
    .second_queue_data_clear_n(bus.second_queue_data_clear_n),
    .rx_port_mailbox_select(bus.rx_port_mailbox_select),
    .endian_order_select(bus.endian_order_select),
    .fall_through_timing(bus.fall_through_timing),
    .tx_port_width_select(bus.tx_port_width_select),
    .rx_port_width_select(bus.rx_port_width_select),
    .tx_read_en(bus.tx_read_en), .rx_write_en(bus.rx_write_en),
    .first_queue_write_ready(bus.first_queue_write_ready),
    .second_queue_write_ready(bus.second_queue_write_ready),
    .first_queue_read_ready(bus.first_queue_read_ready));

  // ==========================================
  // Queue memory stand-ins
  always @(posedge clk_sys_in)
    if (q1_pop_out)
      q1_valid_in <= 1'b0;
  always @(posedge clk_sys_in)
    if (q2_push_out)
    begin
      n_push <= n_push + 1;
      push_word <= q2_data_out;
    end

  // ==========================================
  // Tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [LONG_W-1:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Byte parts carry junk above the lane so ignored lines are really exercised
  function automatic logic [NARROW_W-1:0] part(input logic [LONG_W-1:0] w, input int i,
    input logic bm, big);
    int k;
    k = bm ? (big ? i : 3 - i) : (big ? 2 * i : 2 - 2 * i);
    part = bm ? {9'h155, w[35 - 9 * k -: 9]} : w[35 - 9 * k -: 18];
  endfunction

  task automatic cfg(input logic big, bm);
    start_reset_in <= 1'b1;
    big_endian_in <= big;
    fall_through_in <= big;
    tx_byte_in <= bm;
    rx_byte_in <= bm;
    @(posedge clk_sys_in);
    start_reset_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    while (busy_out) @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [NARROW_W-1:0] d);
    wr_req_in <= 1'b1;
    wr_data_in <= d;
    @(posedge clk_sys_in);
    wr_req_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic rd(output logic [NARROW_W-1:0] d);
    while (!bus.first_queue_read_ready) @(posedge clk_sys_in);
    rd_req_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_req_in <= 1'b0;
    @(posedge clk_sys_in);
    while (!rd_valid_out) @(posedge clk_sys_in);
    d = rd_data_out;
  endtask

  task automatic load(input logic [LONG_W-1:0] w);
    q1_data_in <= w;
    q1_valid_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic offs(input string what, input logic inv);
    repeat (4) @(posedge clk_sys_in);
    for (int o = 0; o < 4; o++)
      chk(what, 36'({OFS_W{inv}} ^ OV[o]), 36'(ofs[o]));
  endtask

  // ==========================================
  // Watchdog, far above the few hundred cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========================================
  // Main sequence
  initial
  begin
    logic [NARROW_W-1:0] d;
    logic [LONG_W-1:0]   w;
    int                  np;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    chk("offset reset", 36'(OFS_RESET), 36'(ofs[0]));
    for (int m = 0; m < 4; m++)
    begin
      load(W0);
      cfg(m[0], m[1]);
      w = W0 ^ {4{9'(m)}};
      np = n_push;
      for (int i = 0; i < (m[1] ? 4 : 2); i++)
        wr(part(w, i, m[1], m[0]));
      chk("rx push count", 36'(np + 1), 36'(n_push));
      chk("rx long word", w, push_word);
      for (int k = 0; k < 2; k++)
      begin
        load(k ? ~w : w);
        for (int i = 0; i < (m[1] ? 4 : 2); i++)
        begin
          rd(d);
          if (m[1])
            d[17:9] = 9'h155;
          chk("tx part", 36'(part(k ? ~w : w, i, m[1], m[0])), 36'(d));
        end
      end
    end
    cfg(1'b1, 1'b0);
    for (int o = 0; o < 4; o++)
      for (int b = OFS_W - 1; b >= 0; b--)
      begin
        ser_bit_in <= OV[o][b];
        ser_req_in <= 1'b1;
        @(posedge clk_sys_in);
        ser_req_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
      end
    offs("serial offset", 1'b0);
    cfg(1'b0, 1'b0);
    for (int o = 0; o < 4; o++)
    begin
      par_data_in <= 36'(~OV[o]);
      par_load_in <= 1'b1;
      @(posedge clk_sys_in);
      par_load_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
    end
    offs("parallel offset", 1'b1);
    wrap_up();
  end
endmodule
